// ---- bench/cs_timing_ctrl_props.sv ----
// Select timing checker bound to the top module
// Assumes full-word register writes from the bench
`timescale 1ns/1ns
`include "cs_timing_params.svh"
module cs_timing_ctrl_props (
    // Clocks and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        link_clk,
    // Register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Pins
    input wire logic [3:0]  slave_select_lines_n,
    input wire logic        select_oe_n,
    input wire logic        slave_enable_handshake_n,
    input wire logic        serial_clock_pin,
    input wire logic        serial_data_out,
    input wire logic        serial_data_in
);
    // ====
    // Register shadows and edge gap counter
    logic [31:0] dly, next_dly;
    logic        mst, next_mst, inset, next_inset, lsck, lidle;
    logic        idle, acc, chg;
    logic [9:0]  cnt, next_cnt, sexp, hexp;
    always_comb begin
        idle = &slave_select_lines_n;
        acc = avs_write && !avs_waitrequest;
        chg = serial_clock_pin != lsck;
        next_dly = (acc && avs_address == `DLY_OFS) ? avs_writedata : dly;
        next_mst = (acc && avs_address == `CTRL_OFS)
            ? avs_writedata[`CTRL_MASTER] : mst;
        next_cnt = (chg || idle != lidle) ? 10'h000
            : cnt + {9'h000, cnt != 10'h3ff};
        next_inset = (lidle && !idle) || (inset && !chg);
        sexp = (mst && dly[31:24] != 8'h00)
            ? {2'b00, dly[31:24]} + 10'h002 : 10'h000;
        hexp = (mst && dly[23:16] != 8'h00)
            ? {2'b00, dly[23:16]} + 10'h001 : 10'h000;
        if (!rstn) begin
            next_dly = `DLY_RST;
            next_mst = 1'b0;
            next_cnt = 10'h000;
            next_inset = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        dly <= next_dly;
        mst <= next_mst;
        cnt <= next_cnt;
        inset <= next_inset;
        lsck <= serial_clock_pin;
        lidle <= idle;
    end
    // ====
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_setup_min;
        inset && chg |-> cnt >= sexp;
    endproperty
    a_setup_min: assert property (p_setup_min)
        else $error("setup too short");
    property p_setup_max;
        inset && chg |-> cnt <= sexp + 10'd16;
    endproperty
    a_setup_max: assert property (p_setup_max)
        else $error("setup too long");
    property p_hold_min;
        idle && !lidle |-> cnt >= hexp;
    endproperty
    a_hold_min: assert property (p_hold_min)
        else $error("hold too short");
    property p_hold_max;
        idle && !lidle |-> cnt <= hexp + 10'd14;
    endproperty
    a_hold_max: assert property (p_hold_max)
        else $error("hold too long");
    property p_oe_mode;
        select_oe_n == !mst;
    endproperty
    a_oe_mode: assert property (p_oe_mode)
        else $error("select drive wrong");
    property p_first_wait;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_first_wait: assert property (p_first_wait)
        else $error("no wait state");
    property p_wait_bound;
        avs_read || avs_write |-> ##[0:1000] !avs_waitrequest;
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("request never answered");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address >= 5'h14
            |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    c_long_setup: cover property (inset && chg && sexp > 10'd100);
    c_zero_hold: cover property (idle && !lidle && hexp == 10'h000);
    c_slave_frame: cover property (idle && !lidle && !mst);
endmodule
bind cs_timing_ctrl cs_timing_ctrl_props u_props (.*);

// ---- bench/spi_master_cs_timing_delays_tb.sv ----
// Self-checking select timing bench
// Assumes the checker is bound from its own file
`timescale 1ns/1ns
`include "cs_timing_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module spi_master_cs_timing_delays_tb;
    logic        sys_clk, rstn, link_clk, avs_read, avs_write, resp_bit;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable, slave_select_lines_n;
    logic        avs_waitrequest, select_oe_n, slave_enable_handshake_n;
    logic        serial_clock_pin, serial_data_out, serial_data_in;
    logic [7:0]  ena_len, edges;
    int          fails, comparisons, cycles;

    cs_timing_ctrl uut (.*);
    spi_slave_model peer (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = !link_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    // ====
    // Helpers
    task automatic report_and_stop();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [8:0] dly_exp(logic [7:0] v, logic m,
                                           logic [8:0] extra);
        return (m && v != 8'h00) ? {1'b0, v} + extra : 9'h000;
    endfunction
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] n, m, input logic [9:0] cfg);
        logic [31:0] dw;
        dw = {n, m, 16'($urandom)};
        resp_bit <= 1'($urandom);
        ena_len <= 8'($urandom);
        bus(1'b1, `CTRL_OFS, {22'h0, cfg});
        bus(1'b1, `DLY_OFS, dw);
        bus(1'b0, `DLY_OFS, 32'h0);
        `CHK(q, dw)
        bus(1'b1, `DATA_OFS, $urandom);
        // Waits for select release
        bus(1'b1, `CTRL_OFS, {22'h0, cfg});
        bus(1'b0, `STAT_OFS, 32'h0);
        `CHK(q[`STAT_BUSY], 1'b0)
        bus(1'b0, `MEAS_OFS, 32'h0);
        `CHK(q[8:0], dly_exp(n, cfg[0], `SETUP_EXTRA))
        `CHK(q[24:16], dly_exp(m, cfg[0], `HOLD_EXTRA))
        if (cfg[0]) begin
            `CHK(edges, 8'(2 * (cfg[7:4] + 1 + cfg[3])))
            bus(1'b0, `DATA_OFS, 32'h0);
            `CHK(q[15:0], resp_bit ? 16'hffff >> (4'hf - cfg[7:4]) : 16'h0)
        end
        $display("xfer done %h %h %h", n, m, cfg);
    endtask
    // ====
    // Main sequence
    initial begin
        rstn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        resp_bit = 1'b0;
        ena_len = 8'h00;
        void'($urandom(32'hfef7fbce));
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge link_clk);
        bus(1'b0, `DLY_OFS, 32'h0);
        `CHK(q, `DLY_RST)
        bus(1'b0, `CTRL_OFS, 32'h0);
        `CHK(q, `CTRL_RST)
        bus(1'b1, 5'h14, 32'hffff_ffff);
        bus(1'b0, 5'h14, 32'h0);
        `CHK(q, 32'h0)
        $display("register test done");
        xfer(8'h00, 8'h00, 10'h071);
        xfer(8'h01, 8'h01, 10'h1f3);
        xfer(8'hff, 8'hff, 10'h2fd);
        xfer(8'h01, 8'h00, 10'h00f);
        xfer(8'h05, 8'h07, 10'h330);
        repeat (12) xfer(8'($urandom), 8'($urandom), 10'($urandom));
        report_and_stop();
    end
endmodule

// ---- bench/spi_slave_model.sv ----
// Slave device on the select lines, answering one level per frame
// Assumes undriven selects float high through a pull-up
`timescale 1ns/1ns
module spi_slave_model (
    // Clock
    input  wire logic       sys_clk,
    // Pins
    input  wire logic [3:0] slave_select_lines_n,
    input  wire logic       select_oe_n,
    input  wire logic       serial_clock_pin,
    output logic            serial_data_in,
    output logic            slave_enable_handshake_n,
    // Bench control
    input  wire logic       resp_bit,
    input  wire logic [7:0] ena_len,
    output logic [7:0]      edges
);
    logic       on, lon, lsck, tgl;
    logic [7:0] age;
    assign on = !select_oe_n && slave_select_lines_n != 4'hf;
    initial begin
        edges = 8'h00;
        age = 8'hff;
        lon = 1'b0;
        lsck = 1'b0;
        tgl = 1'b0;
        serial_data_in = 1'b0;
        slave_enable_handshake_n = 1'b1;
    end
    always @(posedge sys_clk) begin
        if (on && !lon) begin
            edges <= 8'h00;
            age <= 8'h00;
        end else begin
            age <= age + {7'h00, age != 8'hff};
            if (on && serial_clock_pin != lsck)
                edges <= edges + 8'h01;
        end
        lon <= on;
        lsck <= serial_clock_pin;
        tgl <= !tgl;
        // Released data line shows a changing pattern
        serial_data_in <= on ? resp_bit : tgl;
        // Enable timing is random; master ignores it
        slave_enable_handshake_n <= !(on && age < ena_len);
    end
endmodule

// ---- rtl/cs_timing_ctrl.sv ----
// SPI master chip-select timing sequencer with Avalon-MM registers
// Assumes an Avalon-MM master on sys_clk and a free running link_clk
//
// How it works
// - Delays apply in master mode only
// - Nonzero setup N waits N+2 clocks
// - Zero setup starts transmission at once
// - Phase one adds half serial clock first
// - Nonzero hold M keeps select M+1 clocks
// - Zero hold releases select at once
// - Phase zero adds half serial clock last
// - Hold counts from parity or last data
// - Setup ignores enable handshake line
// - Hold ignores enable handshake line
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "cs_timing_params.svh"
module cs_timing_ctrl
    import cs_timing_pkg::*;
(
    // Clocks and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        link_clk,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Select pins
    output logic      [3:0]  slave_select_lines_n,
    output logic             select_oe_n,
    input  wire logic        slave_enable_handshake_n,
    // Serial pins
    output logic             serial_clock_pin,
    output logic             serial_data_out,
    input  wire logic        serial_data_in
);
    link_xfer_if xfer ();

    logic [31:0] delay_cfg, next_delay_cfg;
    logic [31:0] ctrl_cfg, next_ctrl_cfg;
    logic [15:0] tx_data, next_tx_data;
    logic [15:0] rx_data, next_rx_data;
    logic [31:0] next_readdata;
    logic        ack, next_ack;
    seq_state_t  state, next_state;
    logic [8:0]  count, next_count;
    logic [8:0]  span, next_span;
    logic [8:0]  meas_setup, next_meas_setup;
    logic [8:0]  meas_hold, next_meas_hold;
    logic        start_tgl, next_start_tgl;
    logic [3:0]  select_n, next_select_n;
    logic        master_mode;
    logic [7:0]  setup_val;
    logic [7:0]  hold_val;
    logic        bus_req;
    logic        busy;
    logic        cfg_hit;
    logic        stall;
    logic        wr_take;
    logic        start_req;
    logic        done_pulse;
    logic        ena_n_s;
    logic [31:0] status;
    logic [31:0] meas;

    // ======================================================
    // Helpers
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old,
        input logic [31:0] din,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = din[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ======================================================
    // Crossings into the module clock domain
    toggle_sync u_done (
        .clk    (sys_clk),
        .rstn   (rstn),
        .din    (xfer.done_tgl),
        .level  (),
        .change (done_pulse)
    );

    toggle_sync #(.RESET_LEVEL(1'b1)) u_ena (
        .clk    (sys_clk),
        .rstn   (rstn),
        .din    (slave_enable_handshake_n),
        .level  (ena_n_s),
        .change ()
    );

    link_shifter u_link (
        .link_clk         (link_clk),
        .rstn             (rstn),
        .serial_data_in   (serial_data_in),
        .serial_clock_pin (serial_clock_pin),
        .serial_data_out  (serial_data_out),
        .xfer             (xfer.link)
    );

    // ======================================================
    // Effective delays
    assign master_mode = ctrl_cfg[`CTRL_MASTER];
    // Slave operation runs with both delays forced to zero
    assign setup_val = master_mode ?
        delay_cfg[`SETUP_HI:`SETUP_LO] : 8'h00;
    assign hold_val = master_mode ?
        delay_cfg[`HOLD_HI:`HOLD_LO] : 8'h00;

    // ======================================================
    // Avalon-MM slave
    assign bus_req = avs_read | avs_write;
    assign busy    = state != ST_IDLE;
    assign cfg_hit = avs_address == `DATA_OFS
        || avs_address == `CTRL_OFS;
    // Data and control writes wait for idle; delay writes go through at once
    assign stall   = avs_write && cfg_hit && busy;
    assign avs_waitrequest = bus_req && !ack;
    assign wr_take   = avs_write && ack;
    assign start_req = wr_take && avs_address == `DATA_OFS
        && (|avs_byteenable[1:0]);

    assign status = {27'h0000000, ~ena_n_s, ~&select_n,
        state == ST_HOLD, state == ST_SETUP, busy};
    assign meas = {7'h00, meas_hold, 7'h00, meas_setup};

    always_comb begin
        next_ack       = bus_req && !ack && !stall;
        next_readdata  = avs_readdata;
        next_delay_cfg = delay_cfg;
        next_ctrl_cfg  = ctrl_cfg;
        next_tx_data   = tx_data;
        if (avs_read && !ack) begin
            case (avs_address)
                `DLY_OFS:  next_readdata = delay_cfg;
                `CTRL_OFS: next_readdata = ctrl_cfg;
                `DATA_OFS: next_readdata = {16'h0000, rx_data};
                `STAT_OFS: next_readdata = status;
                `MEAS_OFS: next_readdata = meas;
                default:   next_readdata = 32'h0000_0000;
            endcase
        end
        if (wr_take) begin
            case (avs_address)
                `DLY_OFS: next_delay_cfg = merge_bytes(delay_cfg,
                    avs_writedata, avs_byteenable);
                `CTRL_OFS: next_ctrl_cfg = merge_bytes(ctrl_cfg,
                    avs_writedata, avs_byteenable);
                `DATA_OFS: next_tx_data = 16'(merge_bytes(
                    {16'h0000, tx_data}, avs_writedata,
                    avs_byteenable));
                default: next_tx_data = tx_data;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            delay_cfg    <= `DLY_RST;
            ctrl_cfg     <= `CTRL_RST;
            tx_data      <= `TX_RST;
        end else begin
            ack          <= next_ack;
            avs_readdata <= next_readdata;
            delay_cfg    <= next_delay_cfg;
            ctrl_cfg     <= next_ctrl_cfg;
            tx_data      <= next_tx_data;
        end
    end

    // ======================================================
    // Select sequencer
    always_comb begin
        next_state      = state;
        next_count      = count;
        next_span       = span + 9'h001;
        next_meas_setup = meas_setup;
        next_meas_hold  = meas_hold;
        next_start_tgl  = start_tgl;
        next_select_n   = select_n;
        next_rx_data    = rx_data;
        unique case (state)
            ST_IDLE: begin
                next_span = 9'h000;
                if (start_req) begin
                    next_span     = 9'h001;
                    next_select_n = ~(4'h1
                        << ctrl_cfg[`SEL_HI:`SEL_LO]);
                    if (setup_val == 8'h00) begin
                        // Launch in the same edge as the select
                        next_start_tgl  = ~start_tgl;
                        next_meas_setup = 9'h000;
                        next_state      = ST_RUN;
                    end else begin
                        next_count = {1'b0, setup_val}
                            + `SETUP_EXTRA - 9'h001;
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Only the counter ends the wait, not the handshake
                if (count == 9'h000) begin
                    next_start_tgl  = ~start_tgl;
                    next_meas_setup = span;
                    next_state      = ST_RUN;
                end else begin
                    next_count = count - 9'h001;
                end
            end
            ST_RUN: begin
                next_span = 9'h000;
                // Link signals done after the parity bit if enabled
                if (done_pulse) begin
                    next_rx_data = xfer.rx_data;
                    next_span    = 9'h001;
                    if (hold_val == 8'h00) begin
                        next_select_n  = 4'hf;
                        next_meas_hold = 9'h000;
                        next_state     = ST_IDLE;
                    end else begin
                        next_count = {1'b0, hold_val}
                            + `HOLD_EXTRA - 9'h001;
                        next_state = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // Select stays active whatever the handshake does
                if (count == 9'h000) begin
                    next_select_n  = 4'hf;
                    next_meas_hold = span;
                    next_state     = ST_IDLE;
                end else begin
                    next_count = count - 9'h001;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state      <= ST_IDLE;
            count      <= 9'h000;
            span       <= 9'h000;
            meas_setup <= 9'h000;
            meas_hold  <= 9'h000;
            start_tgl  <= 1'b0;
            select_n   <= 4'hf;
            rx_data    <= 16'h0000;
        end else begin
            state      <= next_state;
            count      <= next_count;
            span       <= next_span;
            meas_setup <= next_meas_setup;
            meas_hold  <= next_meas_hold;
            start_tgl  <= next_start_tgl;
            select_n   <= next_select_n;
            rx_data    <= next_rx_data;
        end
    end

    // ======================================================
    // Outputs and link configuration
    assign slave_select_lines_n = select_n;
    assign select_oe_n    = ~master_mode;
    assign xfer.start_tgl = start_tgl;
    assign xfer.phase     = ctrl_cfg[`CTRL_PHASE];
    assign xfer.polarity  = ctrl_cfg[`CTRL_POL];
    assign xfer.parity_en = ctrl_cfg[`CTRL_PAR];
    assign xfer.char_len  = ctrl_cfg[`LEN_HI:`LEN_LO];
    assign xfer.tx_data   = tx_data;
endmodule

// ---- rtl/cs_timing_params.svh ----
// Register map, field positions, reset values and cycle counts
// Assumes byte addresses on a 32-bit Avalon-MM register bus
`ifndef CS_TIMING_PARAMS_SVH
`define CS_TIMING_PARAMS_SVH

// ==========================================================
// Register offsets
`define DLY_OFS      5'h00
`define CTRL_OFS     5'h04
`define DATA_OFS     5'h08
`define STAT_OFS     5'h0c
`define MEAS_OFS     5'h10

// ==========================================================
// Field positions
`define SETUP_HI     31
`define SETUP_LO     24
`define HOLD_HI      23
`define HOLD_LO      16
`define CTRL_MASTER  0
`define CTRL_PHASE   1
`define CTRL_POL     2
`define CTRL_PAR     3
`define LEN_HI       7
`define LEN_LO       4
`define SEL_HI       9
`define SEL_LO       8
`define STAT_BUSY    0
`define STAT_SETUP   1
`define STAT_HOLD    2
`define STAT_SEL     3
`define STAT_ENA     4
`define MEAS_HOLD_LO 16

// ==========================================================
// Reset values and cycle counts
`define DLY_RST      32'h0000_0000
`define CTRL_RST     32'h0000_00f0
`define TX_RST       16'h0000
`define SETUP_EXTRA  9'h002
`define HOLD_EXTRA   9'h001

`endif

// ---- rtl/cs_timing_pkg.sv ----
// Types shared by the select sequencer and the link shifter
// Assumes nothing beyond a SystemVerilog compiler
package cs_timing_pkg;

    // ======================================================
    // State machines
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_RUN,
        ST_HOLD
    } seq_state_t;

    typedef enum logic [1:0] {
        LK_IDLE,
        LK_LEAD,
        LK_BITS,
        LK_TRAIL
    } link_state_t;

endpackage

// ---- rtl/link_shifter.sv ----
// Serial clock and data shifter on the link clock
// Assumes link_clk runs freely; one link_clk is half a serial clock
`timescale 1ns/1ns
module link_shifter
    import cs_timing_pkg::*;
(
    // Clock and reset
    input  wire logic  link_clk,
    input  wire logic  rstn,
    // Serial pins
    input  wire logic  serial_data_in,
    output logic       serial_clock_pin,
    output logic       serial_data_out,
    // Sequencer side
    link_xfer_if.link  xfer
);
    logic              rst_meta;
    logic              link_rstn;
    logic              start_pulse;
    logic              miso_s;
    logic              pol_s;
    logic              data_bit;
    link_state_t       state, next_state;
    logic              half, next_half;
    logic [4:0]        bits_left, next_bits_left;
    logic [15:0]       tx_sh, next_tx_sh;
    logic [15:0]       rx_sh, next_rx_sh;
    logic [15:0]       rx_word, next_rx_word;
    logic              parity, next_parity;
    logic              sclk, next_sclk;
    logic              dout, next_dout;
    logic              done_tgl, next_done_tgl;

    // ======================================================
    // Crossings into the link domain
    always_ff @(posedge link_clk) begin
        rst_meta  <= rstn;
        link_rstn <= rst_meta;
    end

    toggle_sync u_start (.clk(link_clk), .rstn(link_rstn),
        .din(xfer.start_tgl), .level(), .change(start_pulse));
    toggle_sync u_miso (.clk(link_clk), .rstn(link_rstn),
        .din(serial_data_in), .level(miso_s), .change());
    toggle_sync u_pol (.clk(link_clk), .rstn(link_rstn),
        .din(xfer.polarity), .level(pol_s), .change());

    // ======================================================
    // Bit sequencer
    always_comb begin
        next_state     = state;
        next_half      = half;
        next_bits_left = bits_left;
        next_tx_sh     = tx_sh;
        next_rx_sh     = rx_sh;
        next_rx_word   = rx_word;
        next_parity    = parity;
        next_sclk      = sclk;
        next_dout      = dout;
        next_done_tgl  = done_tgl;
        data_bit = bits_left > {4'h0, xfer.parity_en};
        unique case (state)
            LK_IDLE: begin
                next_sclk = pol_s;
                if (start_pulse) begin
                    next_tx_sh = xfer.tx_data
                        << (5'h0f - {1'b0, xfer.char_len});
                    next_bits_left = {1'b0, xfer.char_len} + 5'h01
                        + {4'h0, xfer.parity_en};
                    next_parity = 1'b0;
                    next_rx_sh  = 16'h0000;
                    next_half   = 1'b0;
                    next_dout   = next_tx_sh[15];
                    next_state  = xfer.phase ? LK_LEAD : LK_BITS;
                end
            end
            LK_LEAD: begin
                next_sclk  = pol_s ^ xfer.phase;
                next_state = LK_BITS;
            end
            LK_BITS: begin
                if (!half) begin
                    next_half = 1'b1;
                    next_sclk = pol_s ^ ~xfer.phase;
                end else begin
                    next_half      = 1'b0;
                    next_bits_left = bits_left - 5'h01;
                    if (data_bit) begin
                        next_rx_sh  = {rx_sh[14:0], miso_s};
                        next_parity = parity ^ tx_sh[15];
                        next_tx_sh  = {tx_sh[14:0], 1'b0};
                    end
                    if (bits_left == 5'h01) begin
                        next_sclk = pol_s;
                        if (xfer.phase) begin
                            next_done_tgl = ~done_tgl;
                            next_rx_word  = next_rx_sh;
                            next_state    = LK_IDLE;
                        end else begin
                            next_state = LK_TRAIL;
                        end
                    end else begin
                        next_sclk = pol_s ^ xfer.phase;
                        if (next_bits_left > {4'h0, xfer.parity_en}) begin
                            next_dout = next_tx_sh[15];
                        end else begin
                            next_dout = next_parity;
                        end
                    end
                end
            end
            LK_TRAIL: begin
                // Half serial clock after the last edge
                next_done_tgl = ~done_tgl;
                next_rx_word  = rx_sh;
                next_state    = LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            state     <= LK_IDLE;
            half      <= 1'b0;
            bits_left <= 5'h00;
            tx_sh     <= 16'h0000;
            rx_sh     <= 16'h0000;
            rx_word   <= 16'h0000;
            parity    <= 1'b0;
            sclk      <= 1'b0;
            dout      <= 1'b0;
            done_tgl  <= 1'b0;
        end else begin
            state     <= next_state;
            half      <= next_half;
            bits_left <= next_bits_left;
            tx_sh     <= next_tx_sh;
            rx_sh     <= next_rx_sh;
            rx_word   <= next_rx_word;
            parity    <= next_parity;
            sclk      <= next_sclk;
            dout      <= next_dout;
            done_tgl  <= next_done_tgl;
        end
    end

    assign serial_clock_pin = sclk;
    assign serial_data_out  = dout;
    assign xfer.done_tgl    = done_tgl;
    assign xfer.rx_data     = rx_word;
endmodule

// ---- rtl/link_xfer_if.sv ----
// Carrier between the select sequencer and the link shifter
// Assumes configuration is held stable while a transfer runs
`timescale 1ns/1ns
interface link_xfer_if;
    logic        start_tgl;
    logic        done_tgl;
    logic        phase;
    logic        polarity;
    logic        parity_en;
    logic [3:0]  char_len;
    logic [15:0] tx_data;
    logic [15:0] rx_data;

    modport ctrl (
        output start_tgl, phase, polarity, parity_en, char_len, tx_data,
        input  done_tgl, rx_data
    );
    modport link (
        input  start_tgl, phase, polarity, parity_en, char_len, tx_data,
        output done_tgl, rx_data
    );
endinterface

// ---- rtl/toggle_sync.sv ----
// Two-stage synchroniser giving the level and a change pulse
// Assumes din comes from another clock domain or a pin
`timescale 1ns/1ns
module toggle_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Crossing
    input  wire logic din,
    output logic      level,
    output logic      change
);
    logic meta;
    logic stage;
    logic last;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta  <= RESET_LEVEL;
            stage <= RESET_LEVEL;
            last  <= RESET_LEVEL;
        end else begin
            meta  <= din;
            stage <= meta;
            last  <= stage;
        end
    end

    assign level  = stage;
    assign change = stage ^ last;
endmodule
